// file: verilog/rf_level_and_antenna_check_consts.vh
// register map, field positions and reset values for the rf level and antenna check block
`ifndef RF_LEVEL_AND_ANTENNA_CHECK_CONSTS_VH
`define RF_LEVEL_AND_ANTENNA_CHECK_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ANT_TEST_OFFSET      16'h610c
`define RF_CONFIG_OFFSET     16'h6110
`define FIELD_STATUS_OFFSET  16'h6111

// ----------------------------------------------------------------
// antenna test register fields
// ----------------------------------------------------------------
`define ANT_UNDER_BIT        7
`define ANT_OVER_BIT         6
`define ANT_LOW_THR_MSB      5
`define ANT_LOW_THR_LSB      4
`define ANT_HIGH_THR_MSB     3
`define ANT_HIGH_THR_LSB     1
`define ANT_EN_BIT           0
`define ANT_TEST_RESET       8'h00

// ----------------------------------------------------------------
// rf config register fields
// ----------------------------------------------------------------
`define RF_BOOST_BIT         7
`define RF_LEVEL_MSB         3
`define RF_LEVEL_LSB         0
`define RF_CONFIG_RESET      8'h00

// ----------------------------------------------------------------
// field status register fields
// ----------------------------------------------------------------
`define FS_PRESENT_BIT       0
`define FS_BOOST_ON_BIT      1
`define FS_DETECTED_BIT      2

`endif

// file: verilog/pin_sync3.v
// three-stage synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ns
module pin_sync3 (
  input  wire clock,
  input  wire sys_rst,
  input  wire din,
  output reg  dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  always @(posedge clock) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // pin_sync3

// file: verilog/rf_level_and_antenna_check.v
// field-strength detector control and antenna presence self test with register port
`timescale 1ns/1ns
`include "rf_level_and_antenna_check_consts.vh"
module rf_level_and_antenna_check (
  input  wire        clock,
  input  wire        sys_rst,
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        unit_power_down,
  input  wire        field_above_level,
  input  wire        current_above_high,
  input  wire        current_below_low,
  output reg  [3:0]  field_sense_level,
  output reg         field_sense_boost,
  output reg  [1:0]  low_threshold_sel,
  output reg  [2:0]  high_threshold_sel,
  output reg         monitor_enable,
  output reg         field_wake,
  output reg         field_irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire field_s;
  wire over_s;
  wire under_s;
  wire pdown_s;

  pin_sync3 u_sync_field (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (field_above_level),
    .dout    (field_s)
  );
  pin_sync3 u_sync_over (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (current_above_high),
    .dout    (over_s)
  );
  pin_sync3 u_sync_under (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (current_below_low),
    .dout    (under_s)
  );
  pin_sync3 u_sync_pdown (
    .clock   (clock),
    .sys_rst (sys_rst),
    .din     (unit_power_down),
    .dout    (pdown_s)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0] ant_ctrl_r;
  reg        ant_under_r;
  reg        ant_over_r;
  reg  [7:0] rf_config_r;
  reg        field_prev_r;
  reg        field_seen_r;

  wire wr_ant    = reg_wr && (reg_addr == `ANT_TEST_OFFSET);
  wire wr_rf     = reg_wr && (reg_addr == `RF_CONFIG_OFFSET);
  wire rd_status = reg_rd && (reg_addr == `FIELD_STATUS_OFFSET);
  wire field_rise = field_s && !field_prev_r;

  always @(posedge clock) begin
    if (sys_rst) begin
      ant_ctrl_r  <= `ANT_TEST_RESET;
      rf_config_r <= `RF_CONFIG_RESET;
    end else begin
      if (wr_ant) begin
        // only threshold and enable bits are writable; flags are read-only
        ant_ctrl_r <= {2'b00, reg_wdata[`ANT_LOW_THR_MSB:`ANT_EN_BIT]};
      end
      if (wr_rf) begin
        rf_config_r <= {reg_wdata[`RF_BOOST_BIT], 3'b000,
                        reg_wdata[`RF_LEVEL_MSB:`RF_LEVEL_LSB]};
      end
    end
  end

  // ----------------------------------------------------------------
  // antenna current flags
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      ant_under_r <= 1'b0;
      ant_over_r  <= 1'b0;
    end else if (ant_ctrl_r[`ANT_EN_BIT]) begin
      // live comparator view while monitoring, no sticky state to lose
      ant_under_r <= under_s;
      ant_over_r  <= over_s;
    end else begin
      ant_under_r <= 1'b0;
      ant_over_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // field detector events
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      field_prev_r <= 1'b0;
      field_seen_r <= 1'b0;
      field_wake   <= 1'b0;
      field_irq    <= 1'b0;
    end else begin
      field_prev_r <= field_s;
      // wake is a level held while a field is seen during power-down
      field_wake   <= field_s && pdown_s;
      field_irq    <= field_rise;
      // set wins over the clear-on-read of the status register
      if (field_rise) begin
        field_seen_r <= 1'b1;
      end else if (rd_status) begin
        field_seen_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // analog control outputs
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      field_sense_level  <= 4'h0;
      field_sense_boost  <= 1'b0;
      low_threshold_sel  <= 2'h0;
      high_threshold_sel <= 3'h0;
      monitor_enable     <= 1'b0;
    end else begin
      field_sense_level  <= rf_config_r[`RF_LEVEL_MSB:`RF_LEVEL_LSB];
      // amplifier draws current, so power-down overrides software
      field_sense_boost  <= rf_config_r[`RF_BOOST_BIT] && !pdown_s;
      low_threshold_sel  <= ant_ctrl_r[`ANT_LOW_THR_MSB:`ANT_LOW_THR_LSB];
      high_threshold_sel <= ant_ctrl_r[`ANT_HIGH_THR_MSB:`ANT_HIGH_THR_LSB];
      monitor_enable     <= ant_ctrl_r[`ANT_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ANT_TEST_OFFSET:
          // result is readable only here
          reg_rdata <= {ant_under_r, ant_over_r, ant_ctrl_r[5:0]};
        `RF_CONFIG_OFFSET:
          reg_rdata <= rf_config_r;
        `FIELD_STATUS_OFFSET:
          reg_rdata <= {5'h00, field_seen_r, field_sense_boost, field_s};
        default:
          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // rf_level_and_antenna_check

// file: bench/rf_check_asserts.sv
// concurrent checks on the rf level and antenna check ports
`timescale 1ns/1ns
`include "rf_level_and_antenna_check_consts.vh"
module rf_check_asserts (
  input wire        clock, sys_rst, reg_wr, reg_rd, unit_power_down, field_above_level,
  input wire        field_sense_boost, monitor_enable, field_wake, field_irq,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata, reg_rdata,
  input wire [3:0]  field_sense_level,
  input wire [2:0]  high_threshold_sel,
  input wire [1:0]  low_threshold_sel
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // eight quiet cycles outlast the pin synchronisers
  sequence s_idle_rd;
    (!monitor_enable)[*8] ##1 (reg_rd && !monitor_enable && reg_addr == `ANT_TEST_OFFSET)
    ##1 !monitor_enable;
  endsequence
  a_boost_pd: assert property (unit_power_down[*8] |-> !field_sense_boost)
    else $error("boost on in power-down");
  a_wake_pd: assert property ((!unit_power_down)[*8] |-> !field_wake)
    else $error("wake while awake");
  a_irq_pulse: assert property (field_irq |=> !field_irq) else $error("long irq");
  a_irq_cause: assert property ((!field_above_level)[*8] |-> !field_irq)
    else $error("irq without field");
  a_rd_window: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  a_flags_off: assert property (s_idle_rd |-> reg_rdata[7:6] == 2'b00)
    else $error("flag while test off");
  a_level_wr: assert property (
    reg_wr && reg_addr == `RF_CONFIG_OFFSET |-> ##2
    field_sense_level == $past(reg_wdata[3:0], 2)) else $error("level lost");
  a_ant_wr: assert property (
    reg_wr && reg_addr == `ANT_TEST_OFFSET |-> ##2 {low_threshold_sel,
    high_threshold_sel, monitor_enable} == $past(reg_wdata[5:0], 2)) else $error("fields lost");
endmodule // rf_check_asserts

// file: bench/antenna_model.sv
// analog side stand-in: regulator current against the selected limits
`timescale 1ns/1ns
module antenna_model (
  input  wire [1:0] low_threshold_sel,
  input  wire [2:0] high_threshold_sel,
  input  wire [7:0] current_ma,
  output wire       current_above_high, current_below_low
);
  // unusable low codes give a limit that nothing falls under
  wire [7:0] lo = low_threshold_sel[1] ? 8'h19 + 8'h0a * low_threshold_sel[0] : 8'h00;
  wire [7:0] hi = high_threshold_sel == 3'h6 ? 8'h82 : 8'h2d + 8'h0f * high_threshold_sel;
  assign current_above_high = current_ma > hi;
  assign current_below_low  = current_ma < lo;
endmodule // antenna_model

// file: bench/tb.sv
// register sequences against the antenna model
`timescale 1ns/1ns
`include "rf_level_and_antenna_check_consts.vh"
module tb;
  localparam [15:0] ant = `ANT_TEST_OFFSET, rfc = `RF_CONFIG_OFFSET, fst = `FIELD_STATUS_OFFSET;
  reg        clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg        unit_power_down = 1'b0, field_above_level = 1'b0;
  reg [15:0] reg_addr = 16'h0000;
  reg [7:0]  reg_wdata = 8'h00, current_ma = 8'h1e, v;
  wire [7:0] reg_rdata;
  wire [3:0] field_sense_level;
  wire [2:0] high_threshold_sel;
  wire [1:0] low_threshold_sel;
  wire       field_sense_boost, monitor_enable, field_wake, field_irq;
  wire       current_above_high, current_below_low;
  integer    fail_count = 0, num_checks = 0, i;
  reg [7:0]  irq_cnt = 8'h00;
  // the interrupt is a single-cycle pulse, so count it instead of sampling it
  always @(posedge clock) begin
    if (field_irq) irq_cnt <= irq_cnt + 8'h01;
  end
  rf_level_and_antenna_check dut (.*);
  antenna_model partner (.*);
  initial forever #20 clock = ~clock;
  task chk(input [7:0] seen, input [7:0] exp);
    num_checks = num_checks + 1;
    fail_count = fail_count + (seen !== exp);
    if (seen !== exp) $display("wrong value at %0t: %h %h", $time, seen, exp);
  endtask
  // a read compares the data standing in the cycle after the strobe
  task acc(input w, input [15:0] a, input [7:0] d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    if (!w) chk(reg_rdata, d);
  endtask
  task settle;
    repeat (8) @(posedge clock);
    #1;
  endtask
  task wrap_up;
    $display("%0d checks, %0d mismatches", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    fail_count = fail_count + 1;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    acc(0, ant, `ANT_TEST_RESET);
    acc(0, rfc, `RF_CONFIG_RESET);
    acc(0, 16'h6000, 8'h00);
    $display("reset values done");
    for (i = 0; i < 16; i = i + 1) begin
      v = {3'b001, i[3:0], 1'b0};
      acc(1, ant, v | 8'hc0);
      acc(0, ant, v);
      chk({3'h0, low_threshold_sel, high_threshold_sel}, {3'h0, v[5:1]});
    end
    $display("threshold codes done");
    acc(1, ant, 8'h21);
    settle;
    acc(0, ant, 8'h21);
    current_ma <= 8'h32;
    settle;
    acc(0, ant, 8'h61);
    current_ma <= 8'h14;
    settle;
    acc(0, ant, 8'ha1);
    acc(1, ant, 8'h20);
    settle;
    acc(0, ant, 8'h20);
    $display("antenna test done");
    acc(1, rfc, 8'hfa);
    acc(0, rfc, 8'h8a);
    chk({3'h0, field_sense_boost, field_sense_level}, 8'h1a);
    unit_power_down <= 1'b1;
    settle;
    chk({7'h0, field_sense_boost}, 8'h00);
    field_above_level <= 1'b1;
    settle;
    chk({7'h0, field_wake}, 8'h01);
    acc(0, fst, 8'h05);
    acc(0, fst, 8'h01);
    chk(irq_cnt, 8'h01);
    unit_power_down <= 1'b0;
    settle;
    acc(0, fst, 8'h03);
    $display("field detector done");
    wrap_up;
  end
endmodule // tb
bind rf_level_and_antenna_check rf_check_asserts chk_i (.*);
